// File: dv/index_transfer_exchange_exec_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module index_transfer_exchange_exec_tb_top;
  logic                 mclk       = 1'b0;
  logic                 rst        = 1'b1;
  logic                 start      = 1'b0;
  logic                 ld         = 1'b0;
  logic [15:0]          opcode     = 16'h0000;
  logic [1:0]           ccr_mode   = 2'h0;
  logic [15:0]          ccr_result = 16'h1234;
  logic [15:0]          ccr_pulled = 16'h5a5a;
  itxe_pkg::itxe_regs_t ld_val;
  itxe_pkg::itxe_regs_t regs_in;
  itxe_pkg::itxe_regs_t regs_out;
  itxe_pkg::itxe_regs_t v;
  itxe_pkg::itxe_wen_t  wen;
  logic                 busy;
  logic                 done;
  logic                 hit;
  logic [7:0]           acc_b_out;
  int                   fails      = 0;
  int                   checked    = 0;

  // Low index words force a borrow into the bank on minus two
  initial v = {16'h1111, 16'h2222, 16'h3333, 16'h0001, 16'h0000, 16'h6666,
               4'h7, 4'h8, 4'h9, 4'ha, 16'hbcde};
  initial ld_val = '0;

  always #10 mclk = ~mclk;

  itxe_exec DUT (.mclk(mclk), .rst(rst), .start(start), .opcode(opcode),
    .regs_in(regs_in), .ccr_mode(ccr_mode), .ccr_result(ccr_result),
    .ccr_pulled(ccr_pulled), .busy(busy), .done(done), .hit(hit),
    .regs_out(regs_out), .acc_b_out(acc_b_out), .wen(wen));

  itxe_regfile_model u_model (.mclk(mclk), .rst(rst), .ld(ld), .ld_val(ld_val),
    .wen(wen), .regs_out(regs_out), .acc_b_out(acc_b_out), .regs_q(regs_in));

  // ****************************************************************
  // Checking and closing
  // ****************************************************************
  task automatic chk(input string nm, input logic [127:0] exp, input logic [127:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Reference result worked out from the transfer table
  function automatic itxe_pkg::itxe_regs_t exp_regs(input logic [15:0] op,
                                                    input itxe_pkg::itxe_regs_t a);
    itxe_pkg::itxe_regs_t r;
    r = a;
    case (op)
      itxe_pkg::OP_COPY_Y_TO_STACK: begin
        {r.stack_bank, r.stack_pointer} = {a.index_y_bank, a.index_y} - 20'h00002;
      end
      itxe_pkg::OP_COPY_Z_TO_STACK: begin
        {r.stack_bank, r.stack_pointer} = {a.index_z_bank, a.index_z} - 20'h00002;
      end
      itxe_pkg::OP_COPY_Y_TO_X: {r.index_x_bank, r.index_x} = {a.index_y_bank, a.index_y};
      itxe_pkg::OP_COPY_Y_TO_Z: {r.index_z_bank, r.index_z} = {a.index_y_bank, a.index_y};
      itxe_pkg::OP_COPY_Z_TO_X: {r.index_x_bank, r.index_x} = {a.index_z_bank, a.index_z};
      itxe_pkg::OP_COPY_Z_TO_Y: {r.index_y_bank, r.index_y} = {a.index_z_bank, a.index_z};
      itxe_pkg::OP_READ_Z_BANK: r.acc_d[7:0] = {4'h0, a.index_z_bank};
      itxe_pkg::OP_SWAP_D_Y: {r.acc_d, r.index_y} = {a.index_y, a.acc_d};
      itxe_pkg::OP_SWAP_D_Z: {r.acc_d, r.index_z} = {a.index_z, a.acc_d};
      itxe_pkg::OP_SWAP_E_X: {r.acc_e, r.index_x} = {a.index_x, a.acc_e};
      itxe_pkg::OP_SWAP_E_Y: {r.acc_e, r.index_y} = {a.index_y, a.acc_e};
      itxe_pkg::OP_SWAP_E_Z: {r.acc_e, r.index_z} = {a.index_z, a.acc_e};
      default: ;
    endcase
    return r;
  endfunction

  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  task automatic load();
    @(posedge mclk);
    ld <= 1'b1;
    ld_val <= v;
    @(posedge mclk);
    ld <= 1'b0;
  endtask

  // Holding start into the busy cycle must not start a second take
  task automatic issue(input logic [15:0] op, input logic [1:0] md, input int hold,
                       input logic exp_busy);
    load();
    @(posedge mclk);
    start <= 1'b1;
    opcode <= op;
    ccr_mode <= md;
    @(posedge mclk);
    if (hold == 1) start <= 1'b0;
    #1;
    chk("busy_c1", {127'h0, exp_busy}, {127'h0, busy});
    chk("done_c1", {127'h0, exp_busy}, {127'h0, done});
    @(posedge mclk);
    start <= 1'b0;
    ccr_mode <= 2'h0;
    #1;
    chk("busy_c2", 128'h0, {127'h0, busy});
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_group();
    logic [15:0] ops [12];
    itxe_pkg::itxe_regs_t e;
    ops = '{itxe_pkg::OP_COPY_Y_TO_STACK, itxe_pkg::OP_COPY_Z_TO_STACK,
            itxe_pkg::OP_COPY_Y_TO_X, itxe_pkg::OP_COPY_Y_TO_Z, itxe_pkg::OP_COPY_Z_TO_X,
            itxe_pkg::OP_COPY_Z_TO_Y, itxe_pkg::OP_READ_Z_BANK, itxe_pkg::OP_SWAP_D_Y,
            itxe_pkg::OP_SWAP_D_Z, itxe_pkg::OP_SWAP_E_X, itxe_pkg::OP_SWAP_E_Y,
            itxe_pkg::OP_SWAP_E_Z};
    // A pending flag result must not reach the flags of a group move
    for (int i = 0; i < 12; i++) begin
      issue(ops[i], 2'h1, 1, 1'b1);
      e = exp_regs(ops[i], v);
      chk("hit", 128'h1, {127'h0, hit});
      if (i < 7) begin
        chk("moves", e, regs_in);
      end else begin
        chk("swaps", e, regs_in);
      end
    end
  endtask

  task automatic test_ccr();
    itxe_pkg::itxe_regs_t e;
    for (int m = 1; m < 4; m++) begin
      issue(16'h0000, m[1:0], 1, 1'b1);
      e = v;
      if (m == 1) e.cond_code_reg = {16'h1234 & 16'hfff0} | (v.cond_code_reg & 16'h000f);
      if (m == 2) e.cond_code_reg = 16'h5a5a;
      if (m == 3) e.cond_code_reg = (v.cond_code_reg & 16'hfff0) | 16'h000a;
      chk("ccr_merge", e, regs_in);
    end
    issue(16'h0000, 2'h0, 1, 1'b0);
    chk("refused", v, regs_in);
    chk("hit_none", 128'h0, {127'h0, hit});
  endtask

  task automatic test_held_start();
    issue(itxe_pkg::OP_SWAP_D_Y, 2'h0, 2, 1'b1);
    chk("single_swap", exp_regs(itxe_pkg::OP_SWAP_D_Y, v), regs_in);
  endtask

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    test_group();
    test_ccr();
    test_held_start();
    end_sim();
  end

  initial begin
    repeat (3000) @(posedge mclk);
    fails++;
    end_sim();
  end
endmodule

`default_nettype wire

// File: dv/itxe_regfile_model.sv
`timescale 1ns/10ps
`default_nettype none

// ******************************************************************
// Register file partner
// ******************************************************************
module itxe_regfile_model (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 ld,
  input  wire itxe_pkg::itxe_regs_t ld_val,
  input  wire itxe_pkg::itxe_wen_t  wen,
  input  wire itxe_pkg::itxe_regs_t regs_out,
  input  wire logic [7:0]           acc_b_out,
  output var itxe_pkg::itxe_regs_t  regs_q
);
  // Only strobed fields move, so a stray strobe shows as a wrong value
  always_ff @(posedge mclk) begin
    if (rst) begin
      regs_q <= '0;
    end else if (ld) begin
      regs_q <= ld_val;
    end else begin
      if (wen.d) regs_q.acc_d <= regs_out.acc_d;
      if (wen.b) regs_q.acc_d[7:0] <= acc_b_out; // B is the low byte of D
      if (wen.e) regs_q.acc_e <= regs_out.acc_e;
      if (wen.x) regs_q.index_x <= regs_out.index_x;
      if (wen.x) regs_q.index_x_bank <= regs_out.index_x_bank;
      if (wen.y) regs_q.index_y <= regs_out.index_y;
      if (wen.y) regs_q.index_y_bank <= regs_out.index_y_bank;
      if (wen.z) regs_q.index_z <= regs_out.index_z;
      if (wen.z) regs_q.index_z_bank <= regs_out.index_z_bank;
      if (wen.sp) regs_q.stack_pointer <= regs_out.stack_pointer;
      if (wen.sp) regs_q.stack_bank <= regs_out.stack_bank;
      if (wen.ccr) regs_q.cond_code_reg <= regs_out.cond_code_reg;
    end
  end
endmodule

`default_nettype wire

// File: verilog/itxe_ccr_merge.sv
`timescale 1ns/10ps
`default_nettype none

// ******************************************************************
// Condition code merge
// ******************************************************************
module itxe_ccr_merge (
  input  wire logic                    [1:0]  mode,
  input  wire logic                    [15:0] ccr_now,
  input  wire logic                    [15:0] ccr_result,
  input  wire logic                    [15:0] ccr_pulled,
  output logic                         [15:0] ccr_next,
  output logic                                ccr_change
);

  // Select source per mode; masks keep the untouched field
  always_comb begin
    ccr_next   = ccr_now;
    ccr_change = 1'b0;
    case (itxe_pkg::itxe_ccr_mode_t'(mode))
      itxe_pkg::CCR_RESULT: begin
        ccr_next   = (ccr_result & itxe_pkg::CCR_RESULT_MASK)
                   | (ccr_now & itxe_pkg::CCR_BANK_MASK);
        ccr_change = 1'b1;
      end
      itxe_pkg::CCR_FULL_POP: begin
        ccr_next   = ccr_pulled;
        ccr_change = 1'b1;
      end
      itxe_pkg::CCR_BANK_POP: begin
        ccr_next   = (ccr_pulled & itxe_pkg::CCR_BANK_MASK)
                   | (ccr_now & itxe_pkg::CCR_RESULT_MASK);
        ccr_change = 1'b1;
      end
      default: begin
        ccr_next   = ccr_now;
        ccr_change = 1'b0;
      end
    endcase
  end

endmodule

`default_nettype wire

// File: verilog/itxe_exec.sv
`timescale 1ns/10ps
`default_nettype none

module itxe_exec (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    start,
  input  wire logic [15:0]             opcode,
  input  wire itxe_pkg::itxe_regs_t    regs_in,
  input  wire logic [1:0]              ccr_mode,
  input  wire logic [15:0]             ccr_result,
  input  wire logic [15:0]             ccr_pulled,
  output logic                         busy,
  output logic                         done,
  output logic                         hit,
  output itxe_pkg::itxe_regs_t         regs_out,
  output logic [7:0]                   acc_b_out,
  output itxe_pkg::itxe_wen_t          wen
);

  // ****************************************************************
  // Decode
  // ****************************************************************
  function automatic logic is_op(input logic [15:0] op, input logic [15:0] ref_op);
    is_op = (op == ref_op);
  endfunction

  function automatic logic [19:0] pair(input logic [3:0] bank, input logic [15:0] idx);
    pair = {bank, idx};
  endfunction

  wire logic dec_ys  = is_op(opcode, itxe_pkg::OP_COPY_Y_TO_STACK);
  wire logic dec_zs  = is_op(opcode, itxe_pkg::OP_COPY_Z_TO_STACK);
  wire logic dec_yx  = is_op(opcode, itxe_pkg::OP_COPY_Y_TO_X);
  wire logic dec_yz  = is_op(opcode, itxe_pkg::OP_COPY_Y_TO_Z);
  wire logic dec_zx  = is_op(opcode, itxe_pkg::OP_COPY_Z_TO_X);
  wire logic dec_zy  = is_op(opcode, itxe_pkg::OP_COPY_Z_TO_Y);
  wire logic dec_zkb = is_op(opcode, itxe_pkg::OP_READ_Z_BANK);
  wire logic dec_dy  = is_op(opcode, itxe_pkg::OP_SWAP_D_Y);
  wire logic dec_dz  = is_op(opcode, itxe_pkg::OP_SWAP_D_Z);
  wire logic dec_ex  = is_op(opcode, itxe_pkg::OP_SWAP_E_X);
  wire logic dec_ey  = is_op(opcode, itxe_pkg::OP_SWAP_E_Y);
  wire logic dec_ez  = is_op(opcode, itxe_pkg::OP_SWAP_E_Z);
  wire logic dec_any = dec_ys | dec_zs | dec_yx | dec_yz | dec_zx | dec_zy | dec_zkb
                     | dec_dy | dec_dz | dec_ex | dec_ey | dec_ez;

  // 20-bit pointers: bank is the upper nibble of the address
  wire logic [19:0] y_pair = pair(regs_in.index_y_bank, regs_in.index_y);
  wire logic [19:0] z_pair = pair(regs_in.index_z_bank, regs_in.index_z);
  wire logic [19:0] s_src  = dec_ys ? y_pair : z_pair;
  wire logic [19:0] s_new  = s_src - itxe_pkg::STACK_ADJUST;

  // ****************************************************************
  // Next results, computed from the sampled register view and the CCR inputs
  // ****************************************************************
  itxe_pkg::itxe_regs_t r_d;
  itxe_pkg::itxe_wen_t  w_d;
  logic [7:0]           b_d;
  logic [15:0]          ccr_next;
  logic                 ccr_change;

  itxe_ccr_merge u_ccr (
    .mode       (ccr_mode),
    .ccr_now    (regs_in.cond_code_reg),
    .ccr_result (ccr_result),
    .ccr_pulled (ccr_pulled),
    .ccr_next   (ccr_next),
    .ccr_change (ccr_change)
  );

  // Defaults pass the view through so unwritten fields stay coherent
  always_comb begin
    r_d = regs_in;
    w_d = '0;
    b_d = 8'h00;
    r_d.cond_code_reg = ccr_next;
    w_d.ccr = ccr_change & ~dec_any;
    if (dec_ys | dec_zs) begin
      r_d.stack_bank    = s_new[19:16];
      r_d.stack_pointer = s_new[15:0];
      w_d.sp = 1'b1;
    end
    if (dec_yx) begin
      r_d.index_x_bank = regs_in.index_y_bank;
      r_d.index_x      = regs_in.index_y;
      w_d.x = 1'b1;
    end
    if (dec_yz) begin
      r_d.index_z_bank = regs_in.index_y_bank;
      r_d.index_z      = regs_in.index_y;
      w_d.z = 1'b1;
    end
    if (dec_zx) begin
      r_d.index_x_bank = regs_in.index_z_bank;
      r_d.index_x      = regs_in.index_z;
      w_d.x = 1'b1;
    end
    if (dec_zy) begin
      r_d.index_y_bank = regs_in.index_z_bank;
      r_d.index_y      = regs_in.index_z;
      w_d.y = 1'b1;
    end
    if (dec_zkb) begin
      b_d   = {itxe_pkg::B_UPPER_FILL, regs_in.index_z_bank};
      w_d.b = 1'b1;
    end
    // Swaps touch only the 16-bit halves; banks stay
    if (dec_dy) begin
      r_d.acc_d   = regs_in.index_y;
      r_d.index_y = regs_in.acc_d;
      w_d.d = 1'b1;
      w_d.y = 1'b1;
    end
    if (dec_dz) begin
      r_d.acc_d   = regs_in.index_z;
      r_d.index_z = regs_in.acc_d;
      w_d.d = 1'b1;
      w_d.z = 1'b1;
    end
    if (dec_ex) begin
      r_d.acc_e   = regs_in.index_x;
      r_d.index_x = regs_in.acc_e;
      w_d.e = 1'b1;
      w_d.x = 1'b1;
    end
    if (dec_ey) begin
      r_d.acc_e   = regs_in.index_y;
      r_d.index_y = regs_in.acc_e;
      w_d.e = 1'b1;
      w_d.y = 1'b1;
    end
    if (dec_ez) begin
      r_d.acc_e   = regs_in.index_z;
      r_d.index_z = regs_in.acc_e;
      w_d.e = 1'b1;
      w_d.z = 1'b1;
    end
  end

  // ****************************************************************
  // Two-cycle sequencer
  // ****************************************************************
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_EXEC
  } itxe_state_t;

  itxe_state_t          state_q;
  itxe_state_t          state_d;
  itxe_pkg::itxe_regs_t regs_q;
  itxe_pkg::itxe_wen_t  wen_q;
  logic [7:0]           b_q;
  // Cycle one captures, cycle two writes back
  wire logic take = start & (state_q == ST_IDLE) & (dec_any | ccr_change);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          state_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      regs_q  <= '0;
      wen_q   <= '0;
      b_q     <= 8'h00;
    end else begin
      state_q <= state_d;
      if (take) begin
        regs_q <= r_d;
        wen_q  <= w_d;
        b_q    <= b_d;
      end
    end
  end

  // Strobes only in the write-back cycle, so the file is written once
  assign busy      = (state_q == ST_EXEC);
  assign done      = busy;
  assign hit       = dec_any;
  assign regs_out  = regs_q;
  assign acc_b_out = b_q;
  assign wen       = busy ? wen_q : '0;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_issue(logic d);
    start && !busy && d;
  endsequence

  // Flag-only requests: no group opcode, a merge mode selected
  sequence s_flag_issue(logic [1:0] md);
    start && !busy && !dec_any && (ccr_mode == md);
  endsequence

  a_stack_from_y: assert property (@(posedge mclk) disable iff (rst)
    s_issue(dec_ys) |=> wen.sp && {regs_out.stack_bank, regs_out.stack_pointer}
      == $past(y_pair) - 20'h00002)
    else $error("stack load from Y wrong");
  a_stack_from_z: assert property (@(posedge mclk) disable iff (rst)
    s_issue(dec_zs) |=> wen.sp && {regs_out.stack_bank, regs_out.stack_pointer}
      == $past(z_pair) - 20'h00002)
    else $error("stack load from Z wrong");
  a_copy_y_x: assert property (@(posedge mclk) disable iff (rst)
    s_issue(dec_yx) |=> wen.x && regs_out.index_x == $past(regs_in.index_y)
      && regs_out.index_x_bank == $past(regs_in.index_y_bank))
    else $error("Y to X copy wrong");
  a_copy_y_z: assert property (@(posedge mclk) disable iff (rst)
    s_issue(dec_yz) |=> wen.z && regs_out.index_z == $past(regs_in.index_y)
      && regs_out.index_z_bank == $past(regs_in.index_y_bank))
    else $error("Y to Z copy wrong");
  a_copy_z_x: assert property (@(posedge mclk) disable iff (rst)
    s_issue(dec_zx) |=> wen.x && regs_out.index_x_bank == $past(regs_in.index_z_bank)
      && regs_out.index_x == $past(regs_in.index_z))
    else $error("Z to X copy wrong");
  a_copy_z_y: assert property (@(posedge mclk) disable iff (rst)
    s_issue(dec_zy) |=> wen.y && regs_out.index_y == $past(regs_in.index_z)
      && regs_out.index_y_bank == $past(regs_in.index_z_bank))
    else $error("Z to Y copy wrong");
  a_z_bank_b: assert property (@(posedge mclk) disable iff (rst)
    s_issue(dec_zkb) |=> wen.b && acc_b_out == {4'h0, $past(regs_in.index_z_bank)})
    else $error("Z bank to B wrong");
  a_swap_d_y: assert property (@(posedge mclk) disable iff (rst)
    s_issue(dec_dy) |=> regs_out.acc_d == $past(regs_in.index_y)
      && regs_out.index_y == $past(regs_in.acc_d))
    else $error("D Y swap wrong");
  a_swap_d_z: assert property (@(posedge mclk) disable iff (rst)
    s_issue(dec_dz) |=> wen.d && wen.z && regs_out.acc_d == $past(regs_in.index_z)
      && regs_out.index_z == $past(regs_in.acc_d))
    else $error("D Z swap wrong");
  a_swap_e_x: assert property (@(posedge mclk) disable iff (rst)
    s_issue(dec_ex) |=> regs_out.acc_e == $past(regs_in.index_x)
      && regs_out.index_x == $past(regs_in.acc_e))
    else $error("E X swap wrong");
  a_swap_e_y: assert property (@(posedge mclk) disable iff (rst)
    s_issue(dec_ey) |=> wen.e && wen.y && regs_out.acc_e == $past(regs_in.index_y)
      && regs_out.index_y == $past(regs_in.acc_e))
    else $error("E Y swap wrong");
  a_swap_e_z: assert property (@(posedge mclk) disable iff (rst)
    s_issue(dec_ez) |=> wen.e && wen.z && regs_out.acc_e == $past(regs_in.index_z)
      && regs_out.index_z == $past(regs_in.acc_e))
    else $error("E Z swap wrong");
  a_two_cycles: assert property (@(posedge mclk) disable iff (rst)
    s_issue(dec_any) |=> busy ##1 !busy)
    else $error("group not two cycles");
  a_ccr_result: assert property (@(posedge mclk) disable iff (rst)
    s_flag_issue(2'h1) |=> wen.ccr
      && regs_out.cond_code_reg[15:4] == $past(ccr_result[15:4])
      && regs_out.cond_code_reg[3:0] == $past(regs_in.cond_code_reg[3:0]))
    else $error("result flag merge wrong");
  a_ccr_full: assert property (@(posedge mclk) disable iff (rst)
    s_flag_issue(2'h2) |=> wen.ccr && regs_out.cond_code_reg == $past(ccr_pulled))
    else $error("full flag restore wrong");
  a_ccr_bank: assert property (@(posedge mclk) disable iff (rst)
    s_flag_issue(2'h3) |=> wen.ccr
      && regs_out.cond_code_reg[3:0] == $past(ccr_pulled[3:0])
      && regs_out.cond_code_reg[15:4] == $past(regs_in.cond_code_reg[15:4]))
    else $error("bank flag restore wrong");
  a_ccr_held: assert property (@(posedge mclk) disable iff (rst)
    s_issue(dec_any) |=> !wen.ccr)
    else $error("group touched CCR");

endmodule

`default_nettype wire

// File: verilog/itxe_pkg.sv
`default_nettype none

package itxe_pkg;

  // ****************************************************************
  // Opcodes of the group
  // ****************************************************************
  localparam logic [15:0] OP_COPY_Y_TO_STACK = 16'h375e;
  localparam logic [15:0] OP_COPY_Z_TO_STACK = 16'h376e;
  localparam logic [15:0] OP_COPY_Y_TO_X     = 16'h274d;
  localparam logic [15:0] OP_COPY_Y_TO_Z     = 16'h276d;
  localparam logic [15:0] OP_COPY_Z_TO_X     = 16'h274e;
  localparam logic [15:0] OP_COPY_Z_TO_Y     = 16'h275e;
  localparam logic [15:0] OP_READ_Z_BANK     = 16'h37ae;
  localparam logic [15:0] OP_SWAP_D_Y        = 16'h37dc;
  localparam logic [15:0] OP_SWAP_D_Z        = 16'h37ec;
  localparam logic [15:0] OP_SWAP_E_X        = 16'h374c;
  localparam logic [15:0] OP_SWAP_E_Y        = 16'h375c;
  localparam logic [15:0] OP_SWAP_E_Z        = 16'h376c;

  // ****************************************************************
  // Timing, constants and field layout
  // ****************************************************************
  localparam int unsigned   EXEC_CYCLES   = 2;
  localparam logic [19:0]   STACK_ADJUST  = 20'h00002;
  localparam logic [3:0]    B_UPPER_FILL  = 4'h0;
  localparam int unsigned   CCR_KEEP_HI   = 15;
  localparam int unsigned   CCR_KEEP_LO   = 4;
  localparam int unsigned   PROG_BANK_HI  = 3;
  localparam int unsigned   PROG_BANK_LO  = 0;
  localparam logic [15:0]   CCR_RESULT_MASK = 16'hfff0;
  localparam logic [15:0]   CCR_BANK_MASK   = 16'h000f;

  // CCR update modes selected by the sequencer
  typedef enum logic [1:0] {
    CCR_HOLD,
    CCR_RESULT,
    CCR_FULL_POP,
    CCR_BANK_POP
  } itxe_ccr_mode_t;

  // Register file view, index and bank pairs
  typedef struct packed {
    logic [15:0] acc_d;
    logic [15:0] acc_e;
    logic [15:0] index_x;
    logic [15:0] index_y;
    logic [15:0] index_z;
    logic [15:0] stack_pointer;
    logic [3:0]  index_x_bank;
    logic [3:0]  index_y_bank;
    logic [3:0]  index_z_bank;
    logic [3:0]  stack_bank;
    logic [15:0] cond_code_reg;
  } itxe_regs_t;

  // Write strobes toward the register file
  typedef struct packed {
    logic d;
    logic e;
    logic b;
    logic x;
    logic y;
    logic z;
    logic sp;
    logic ccr;
  } itxe_wen_t;

endpackage

`default_nettype wire
